/* src/uic_ctrl.v */
`timescale 1ns/10ps
// Contract
// (RL1) FIFOs on and enables 0-3 clear gives polled mode through line status only.
// (RL2) Line status: data, overrun, head errors, holding empty, all empty, any error.
// (RL3) Receive ready: holding full without FIFO, trigger reached with FIFO.
// (RL4) Transmit ready on empty or below trigger; enabling while empty fires.
// (RL5) Overrun interrupts at arrival; parity/framing/break when the char reaches the head.
// (RL6) Modem status interrupt when any of the four change bits is set.
// (RL7) Upper four enables act only with enhanced enable; all reset to zero.
// (RL8) Flow pin interrupts on rising request or clear-to-send under auto flow.
// (RL9) Time-out after four chars plus twelve bits with data; receive read clears.
// (RL10) Status bits 5..0 encode the pending source by fixed priority.
// (RL11) Status shows only the highest pending source; others stay queued.
// (RL12) Status bit 0 is 0 while pending, 1 when idle and at reset.
// (RL13) Clears: line status read, level drop, status read or write, modem read.
// (RL14) Xoff clears on status read or Xon; special on read or next char.
// (RL15) Status bits 4 and 5 only with enhanced enable.
// (RL16) Status bits 7:6 read 11 with FIFOs on, 00 with them off.
// (RL17) FIFO control writes with bit 0 clear ignore the other bits.
// (RL18) Receive FIFO reset pulse, self clearing, only with FIFOs on.
// (RL19) Transmit FIFO reset pulse, self clearing, only with FIFOs on.
// (RL20) Bit 3 selects normal or DMA behaviour of the ready pins.
// (RL21) Transmit trigger 16/8/24/30, written only with enhanced enable.
// (RL22) Receive trigger 8/16/24/28; receive interrupt at that level.
// (RL23) Data ready sets on a char entering the FIFO, clears when empty.
// (RL24) Disabled sources never reach the status code or the interrupt.
`include "uic_defs.vh"

module uic_ctrl (
   // Clock and reset
   input wire sys_clk,
   input wire nrst,
   input wire clk_en,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // Receive side
   input wire [7:0] rx_data,
   input wire [5:0] rx_count,
   input wire rx_char_loaded,
   input wire rx_overrun,
   input wire [2:0] rx_head_err,
   input wire rx_any_err,
   input wire bit_tick,
   input wire [3:0] frame_bits,
   output reg rx_pop,
   output reg rx_fifo_reset,
   // Transmit side
   input wire [5:0] tx_count,
   input wire tx_shift_empty,
   output reg tx_push,
   output reg [7:0] tx_data,
   output reg tx_fifo_reset,
   // Modem and flow control
   input wire [7:0] modem_status,
   input wire enhanced_en,
   input wire auto_rts_en,
   input wire auto_cts_en,
   input wire rts_rise,
   input wire cts_rise,
   input wire xoff_det,
   input wire xon_det,
   input wire special_det,
   output reg modem_status_rd,
   // Mode outputs and pins
   output reg fifo_en,
   output reg dma_mode,
   output reg sleep_en,
   output reg [5:0] rx_trig_level,
   output reg [5:0] tx_trig_level,
   output reg receive_ready_pin_n,
   output reg transmit_ready_pin_n,
   output reg irq
);

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   wire setup = psel & ~penable & clk_en;
   wire acc = psel & penable & clk_en;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire hit_data = (paddr == `UIC_ADDR_DATA);
   wire hit_ien = (paddr == `UIC_ADDR_IEN);
   wire hit_istat = (paddr == `UIC_ADDR_ISTAT);
   wire hit_lstat = (paddr == `UIC_ADDR_LSTAT);
   wire hit_mstat = (paddr == `UIC_ADDR_MSTAT);
   wire mapped = hit_data | hit_ien | hit_istat | hit_lstat | hit_mstat;

   // Every access completes in one access cycle; frozen clock stalls it
   assign pready = clk_en;

   wire rd_data = rd & hit_data;
   wire rd_istat = rd & hit_istat;
   wire rd_lstat = rd & hit_lstat;
   wire rd_mstat = rd & hit_mstat;
   wire wr_data = wr & hit_data;
   wire wr_fc = wr & hit_istat;

   // ****************************************************************
   // Control registers
   // ****************************************************************
   reg [7:0] ien_q;
   reg [1:0] rx_sel_q;
   reg [1:0] tx_sel_q;

   // Upper enables are masked, not cleared, so they reappear with enhanced mode
   wire [7:0] ien_eff = {ien_q[7:4] & {4{enhanced_en}}, ien_q[3:0]}; // RL7

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ien_q <= `UIC_IEN_RST; // RL7
         fifo_en <= 1'b0;
         dma_mode <= 1'b0;
         rx_sel_q <= `UIC_TRIG_RST;
         tx_sel_q <= `UIC_TRIG_RST;
         rx_fifo_reset <= 1'b0;
         tx_fifo_reset <= 1'b0;
         tx_push <= 1'b0;
         tx_data <= 8'h00;
         rx_pop <= 1'b0;
         modem_status_rd <= 1'b0;
      end else if (clk_en) begin
         rx_fifo_reset <= 1'b0; // RL18
         tx_fifo_reset <= 1'b0; // RL19
         tx_push <= wr_data;
         rx_pop <= rd_data;
         modem_status_rd <= rd_mstat;
         if (wr_data) begin
            tx_data <= pwdata[7:0];
         end
         if (wr & hit_ien) begin
            ien_q <= pwdata[7:0];
         end
         if (wr_fc) begin
            fifo_en <= pwdata[`UIC_FC_EN];
            if (pwdata[`UIC_FC_EN]) begin // RL17
               rx_fifo_reset <= pwdata[`UIC_FC_RXRST]; // RL18
               tx_fifo_reset <= pwdata[`UIC_FC_TXRST]; // RL19
               dma_mode <= pwdata[`UIC_FC_DMA]; // RL20
               rx_sel_q <= pwdata[7:6]; // RL22
               if (enhanced_en) begin
                  tx_sel_q <= pwdata[5:4]; // RL21
               end
            end
         end
      end
   end

   always @* begin
      sleep_en = ien_eff[`UIC_IEN_SLEEP];
      case (rx_sel_q) // RL22
         2'b00: rx_trig_level = `UIC_RX_TRIG0;
         2'b01: rx_trig_level = `UIC_RX_TRIG1;
         2'b10: rx_trig_level = `UIC_RX_TRIG2;
         default: rx_trig_level = `UIC_RX_TRIG3;
      endcase
      case (tx_sel_q) // RL21
         2'b00: tx_trig_level = `UIC_TX_TRIG0;
         2'b01: tx_trig_level = `UIC_TX_TRIG1;
         2'b10: tx_trig_level = `UIC_TX_TRIG2;
         default: tx_trig_level = `UIC_TX_TRIG3;
      endcase
   end

   // ****************************************************************
   // Line status
   // ****************************************************************
   reg ovr_q;
   reg [2:0] err_q;
   wire [7:0] lstat;

   assign lstat = {rx_any_err, (tx_count == 6'h00) & tx_shift_empty, tx_count == 6'h00,
                   err_q, ovr_q, rx_count != 6'h00}; // RL2 RL23

   // Set wins over the read that clears, so an error in that cycle is kept
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ovr_q <= 1'b0;
         err_q <= 3'h0;
      end else if (clk_en) begin
         ovr_q <= rx_overrun | (ovr_q & ~rd_lstat); // RL5
         err_q <= rx_head_err | (err_q & {3{~rd_lstat}}); // RL5 RL13
      end
   end

   // ****************************************************************
   // Receive time-out
   // ****************************************************************
   reg [7:0] tmo_cnt_q;
   reg tmo_q;
   wire [7:0] tmo_limit = {frame_bits, 2'b00} + `UIC_TMO_BITS; // RL9
   wire tmo_restart = rx_char_loaded | rx_pop | (rx_count == 6'h00) | ~fifo_en;

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tmo_cnt_q <= 8'h00;
         tmo_q <= 1'b0;
      end else if (clk_en) begin
         if (tmo_restart) begin
            tmo_cnt_q <= 8'h00;
         end else if (bit_tick && tmo_cnt_q != tmo_limit) begin
            tmo_cnt_q <= tmo_cnt_q + 8'h01;
         end
         if (!tmo_restart && bit_tick && tmo_cnt_q + 8'h01 == tmo_limit) begin
            tmo_q <= 1'b1; // RL9
         end else if (rd_data) begin
            tmo_q <= 1'b0; // RL9
         end
      end
   end

   // ****************************************************************
   // Transmit ready
   // ****************************************************************
   reg txr_q;
   reg [5:0] tx_prev_q;
   reg tx_over_q;
   reg ien_tx_prev_q;
   wire tx_below = fifo_en & (tx_prev_q >= tx_trig_level) & (tx_count < tx_trig_level);
   wire tx_empty_edge = (tx_prev_q != 6'h00) & (tx_count == 6'h00);
   wire tx_set = tx_below | (tx_empty_edge & (~fifo_en | ~tx_over_q)) |
                 (ien_eff[`UIC_IEN_TRANSMIT_READY_PIN_N] & ~ien_tx_prev_q & (tx_count == 6'h00)); // RL4 RL21
   wire [5:0] isr_code;

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         txr_q <= 1'b0;
         tx_prev_q <= 6'h00;
         tx_over_q <= 1'b0;
         ien_tx_prev_q <= 1'b0;
      end else if (clk_en) begin
         tx_prev_q <= tx_count;
         ien_tx_prev_q <= ien_eff[`UIC_IEN_TRANSMIT_READY_PIN_N];
         if (tx_count > tx_trig_level) begin
            tx_over_q <= 1'b1;
         end else if (tx_count == 6'h00) begin
            tx_over_q <= 1'b0;
         end
         if (tx_set) begin
            txr_q <= 1'b1;
         end else if (wr_data || (rd_istat && isr_code == `UIC_IS_TRANSMIT_READY_PIN_N)) begin
            txr_q <= 1'b0; // RL13
         end
      end
   end

   // ****************************************************************
   // Xoff / special character and flow pin events
   // ****************************************************************
   reg xs_q;
   reg xs_special_q;
   reg fp_q;
   wire fp_set = (rts_rise & auto_rts_en & ien_eff[`UIC_IEN_RTS]) |
                 (cts_rise & auto_cts_en & ien_eff[`UIC_IEN_CTS]); // RL8

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         xs_q <= 1'b0;
         xs_special_q <= 1'b0;
         fp_q <= 1'b0;
      end else if (clk_en) begin
         if (xoff_det | special_det) begin
            xs_q <= 1'b1;
            xs_special_q <= special_det;
         end else if ((rd_istat && isr_code == `UIC_IS_XOFF) || (xon_det && !xs_special_q) ||
                      (rx_char_loaded && xs_special_q)) begin
            xs_q <= 1'b0; // RL14
         end
         if (fp_set) begin
            fp_q <= 1'b1;
         end else if (rd_mstat) begin
            fp_q <= 1'b0; // RL13
         end
      end
   end

   // ****************************************************************
   // Interrupt sources and priority
   // ****************************************************************
   wire src_ls = ien_eff[`UIC_IEN_LSTAT] & (ovr_q | (err_q != 3'h0)); // RL5 RL24
   wire src_tmo = ien_eff[`UIC_IEN_RECEIVE_READY_PIN_N] & tmo_q; // RL9 RL24
   wire src_rx = ien_eff[`UIC_IEN_RECEIVE_READY_PIN_N] &
                 (fifo_en ? (rx_count >= rx_trig_level) : (rx_count != 6'h00)); // RL3 RL13
   wire src_tx = ien_eff[`UIC_IEN_TRANSMIT_READY_PIN_N] & txr_q; // RL4 RL24
   wire src_ms = ien_eff[`UIC_IEN_MSTAT] & (modem_status[3:0] != 4'h0); // RL6
   wire src_xs = ien_eff[`UIC_IEN_XOFF] & xs_q; // RL15 RL24
   wire src_fp = enhanced_en & fp_q & (ien_eff[`UIC_IEN_RTS] | ien_eff[`UIC_IEN_CTS]); // RL15 RL24
   wire [6:0] src = {src_fp, src_xs, src_ms, src_tx, src_rx, src_tmo, src_ls};

   // Lower sources stay asserted underneath until the higher one is serviced
   assign isr_code = src[0] ? `UIC_IS_LSTAT :
                     src[1] ? `UIC_IS_TMO :
                     src[2] ? `UIC_IS_RECEIVE_READY_PIN_N :
                     src[3] ? `UIC_IS_TRANSMIT_READY_PIN_N :
                     src[4] ? `UIC_IS_MSTAT :
                     src[5] ? `UIC_IS_XOFF :
                     src[6] ? `UIC_IS_FLOW : `UIC_IS_NONE; // RL10 RL11 RL12

   // ****************************************************************
   // Read data, ready pins and interrupt line
   // ****************************************************************
   reg [7:0] rd_mux;

   always @* begin
      case (1'b1)
         hit_data: rd_mux = rx_data;
         hit_ien: rd_mux = ien_q;
         hit_istat: rd_mux = {fifo_en, fifo_en, isr_code}; // RL16
         hit_lstat: rd_mux = lstat; // RL1
         hit_mstat: rd_mux = modem_status;
         default: rd_mux = 8'h00;
      endcase
   end

   // Read data is sampled in the setup cycle, so it is stable for the access
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         receive_ready_pin_n <= 1'b1;
         transmit_ready_pin_n <= 1'b1;
         irq <= 1'b0;
      end else if (clk_en) begin
         if (setup) begin
            prdata <= {24'h00_0000, pwrite ? 8'h00 : rd_mux};
            pslverr <= ~mapped;
         end
         irq <= (src != 7'h00); // RL24
         if (dma_mode && fifo_en) begin
            receive_ready_pin_n <= ~((rx_count >= rx_trig_level) | tmo_q); // RL20
            transmit_ready_pin_n <= ~(tx_count < `UIC_FIFO_DEPTH); // RL20
         end else begin
            receive_ready_pin_n <= ~(rx_count != 6'h00);
            transmit_ready_pin_n <= ~(tx_count == 6'h00);
         end
      end
   end

endmodule

/* src/uic_defs.vh */
`ifndef UIC_DEFS_VH
`define UIC_DEFS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define UIC_ADDR_DATA 8'h00
`define UIC_ADDR_IEN 8'h04
`define UIC_ADDR_ISTAT 8'h08
`define UIC_ADDR_LSTAT 8'h14
`define UIC_ADDR_MSTAT 8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define UIC_IEN_RECEIVE_READY_PIN_N 0
`define UIC_IEN_TRANSMIT_READY_PIN_N 1
`define UIC_IEN_LSTAT 2
`define UIC_IEN_MSTAT 3
`define UIC_IEN_SLEEP 4
`define UIC_IEN_XOFF 5
`define UIC_IEN_RTS 6
`define UIC_IEN_CTS 7
`define UIC_FC_EN 0
`define UIC_FC_RXRST 1
`define UIC_FC_TXRST 2
`define UIC_FC_DMA 3

// ****************************************************************
// Reset values
// ****************************************************************
`define UIC_IEN_RST 8'h00
`define UIC_TRIG_RST 2'h0

// ****************************************************************
// Interrupt status codes, bits 5..0
// ****************************************************************
`define UIC_IS_LSTAT 6'h06
`define UIC_IS_TMO 6'h0C
`define UIC_IS_RECEIVE_READY_PIN_N 6'h04
`define UIC_IS_TRANSMIT_READY_PIN_N 6'h02
`define UIC_IS_MSTAT 6'h00
`define UIC_IS_XOFF 6'h10
`define UIC_IS_FLOW 6'h20
`define UIC_IS_NONE 6'h01

// ****************************************************************
// FIFO levels and timing
// ****************************************************************
`define UIC_TX_TRIG0 6'h10
`define UIC_TX_TRIG1 6'h08
`define UIC_TX_TRIG2 6'h18
`define UIC_TX_TRIG3 6'h1E
`define UIC_RX_TRIG0 6'h08
`define UIC_RX_TRIG1 6'h10
`define UIC_RX_TRIG2 6'h18
`define UIC_RX_TRIG3 6'h1C
`define UIC_FIFO_DEPTH 6'h20
`define UIC_TMO_CHARS 8'h04
`define UIC_TMO_BITS 8'h0C

`endif

/* tb/uic_ctrl_monitor.sv */
`timescale 1ns/10ps
module uic_ctrl_monitor (
   // Clock and reset
   input logic sys_clk,
   input logic nrst,
   input logic clk_en,
   // APB
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   // Mode and side outputs
   input logic rx_fifo_reset,
   input logic tx_fifo_reset,
   input logic rx_pop,
   input logic fifo_en,
   input logic dma_mode,
   input logic sleep_en,
   input logic enhanced_en,
   input logic [5:0] rx_trig_level,
   input logic [5:0] tx_trig_level
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire rd_st = psel && penable && !pwrite && paddr == 8'h08;
   wire wr_fc = psel && penable && pwrite && clk_en && paddr == 8'h08;
   // ****************
   // Checks
   // ****************
   a_fifo_status_bits: assert property (rd_st |-> prdata[7:6] == {2{fifo_en}})
      else $error("status bits 7:6 disagree with fifo enable");
   a_status_code_set: assert property (rd_st |-> prdata[5:0] inside {6'h06, 6'h0C, 6'h04, 6'h02,
      6'h00, 6'h10, 6'h20, 6'h01})
      else $error("status code outside the priority table");
   a_rx_reset_single: assert property (rx_fifo_reset |=> !rx_fifo_reset)
      else $error("receive fifo reset did not self clear");
   a_rx_reset_cause: assert property ($rose(rx_fifo_reset) |-> $past(wr_fc && pwdata[1] && pwdata[0]))
      else $error("receive fifo reset without an enabled request");
   a_tx_reset_cause: assert property ($rose(tx_fifo_reset) |-> $past(wr_fc && pwdata[2] && pwdata[0]))
      else $error("transmit fifo reset without an enabled request");
   a_fifo_off_keep: assert property (wr_fc && !pwdata[0] |=> !fifo_en && $stable(dma_mode)
      && $stable(rx_trig_level))
      else $error("write with fifo bit clear changed other fields");
   a_dma_follows: assert property (wr_fc && pwdata[0] |=> dma_mode == $past(pwdata[3]))
      else $error("dma mode does not follow the write");
   a_rx_trig_set: assert property (rx_trig_level inside {6'h08, 6'h10, 6'h18, 6'h1C})
      else $error("receive trigger level off table");
   a_tx_trig_set: assert property (tx_trig_level inside {6'h10, 6'h08, 6'h18, 6'h1E})
      else $error("transmit trigger level off table");
   a_sleep_gated: assert property (sleep_en |-> enhanced_en)
      else $error("sleep enabled without enhanced enable");
   a_pop_cause: assert property ($rose(rx_pop) |-> $past(psel && penable && !pwrite && paddr == 8'h00))
      else $error("receive pop without a data read");
   c_rx_reset: cover property ($rose(rx_fifo_reset));
   c_fifo_off: cover property (wr_fc && !pwdata[0]);
   c_pop: cover property ($rose(rx_pop));
endmodule

bind uic_ctrl uic_ctrl_monitor mon (.*);

/* tb/uic_host.sv */
`timescale 1ns/10ps
module uic_host (
   // Clock
   input logic sys_clk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input logic pready,
   input logic [31:0] prdata,
   input logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // Request held until pready is seen high at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule

/* tb/uic_ctrl_tb.sv */
`timescale 1ns/10ps
`include "uic_defs.vh"
`define CHK(x, y) begin num_checks++; if ((x) !== (y)) begin miscompares++; $display("mismatch at %0t: got %h, expected %h", $time, x, y); end end
module uic_ctrl_tb;
   // ****************
   // Signals
   // ****************
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic clk_en = 1'b1;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] rx_data = 8'h5A, modem_status = 8'h00, tx_data;
   logic [5:0] rx_count = 6'h00, tx_count = 6'h00, rx_trig_level, tx_trig_level;
   logic rx_any_err = 0, bit_tick = 0, tx_shift_empty = 1;
   logic [2:0] rx_head_err = 3'h0;
   logic [3:0] frame_bits = 4'hA;
   logic enhanced_en = 0, auto_rts_en = 0, auto_cts_en = 0, rts_rise = 0;
   // One vector for the event strobes other than rts_rise, so a single task can pulse any of them
   logic [5:0] strobe = 6'h00;
   localparam int ev_ovr = 0, ev_load = 1, ev_xoff = 2, ev_xon = 3, ev_spec = 4, ev_cts = 5;
   wire rx_overrun = strobe[ev_ovr], rx_char_loaded = strobe[ev_load], xoff_det = strobe[ev_xoff];
   wire xon_det = strobe[ev_xon], special_det = strobe[ev_spec], cts_rise = strobe[ev_cts];
   logic rx_pop, rx_fifo_reset, tx_push, tx_fifo_reset, modem_status_rd, fifo_en, dma_mode;
   logic sleep_en, receive_ready_pin_n, transmit_ready_pin_n, irq;
   int num_checks = 0, miscompares = 0, rx_rst = 0, tx_rst = 0, pops = 0, pushes = 0, ms_rds = 0;

   uic_ctrl dut (.*);
   uic_host host (.*);

   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      bit_tick <= ~bit_tick;
      rx_rst <= rx_rst + rx_fifo_reset;
      tx_rst <= tx_rst + tx_fifo_reset;
      pops <= pops + rx_pop;
      pushes <= pushes + tx_push;
      ms_rds <= ms_rds + modem_status_rd;
   end
   // ****************
   // Bus and stimulus helpers
   // ****************
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      host.xfer(1'b1, a, {24'h00_0000, d}, r, e);
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      logic [31:0] r;
      logic e;
      host.xfer(1'b0, a, 32'h0000_0000, r, e);
      `CHK(r, {24'h00_0000, x})
   endtask
   task automatic pulse(input int k);
      @(posedge sys_clk);
      strobe[k] <= 1'b1;
      @(posedge sys_clk);
      strobe[k] <= 1'b0;
      tick(2);
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset;
      logic [31:0] r;
      logic e;
      rd(`UIC_ADDR_IEN, 8'h00);
      rd(`UIC_ADDR_ISTAT, 8'h01);
      host.xfer(1'b0, 8'h3C, 32'h0000_0000, r, e);
      `CHK(e, 1'b1)
      `CHK(irq, 1'b0)
      $display("test reset done");
   endtask
   task automatic t_fifo;
      logic [5:0] rxt[4] = '{6'h08, 6'h10, 6'h18, 6'h1C};
      logic [5:0] txt[4] = '{6'h10, 6'h08, 6'h18, 6'h1E};
      wr(`UIC_ADDR_ISTAT, 8'h09);
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      `CHK(dma_mode, 1'b1)
      wr(`UIC_ADDR_ISTAT, 8'hCE);
      `CHK(fifo_en, 1'b0)
      `CHK(rx_trig_level, 6'h08)
      rd(`UIC_ADDR_ISTAT, 8'h01);
      enhanced_en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(`UIC_ADDR_ISTAT, {i[1:0], i[1:0], 4'h7});
         `CHK(rx_trig_level, rxt[i])
         `CHK(tx_trig_level, txt[i])
      end
      enhanced_en <= 1'b0;
      wr(`UIC_ADDR_ISTAT, 8'h01);
      `CHK(tx_trig_level, 6'h1E)
      `CHK(dma_mode, 1'b0)
      `CHK(rx_rst, 4)
      `CHK(tx_rst, 4)
      $display("test fifo control done");
   endtask
   task automatic t_prio;
      wr(`UIC_ADDR_IEN, 8'h0F);
      tick(2);
      `CHK(irq, 1'b1)
      rd(`UIC_ADDR_ISTAT, 8'hC2);
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      tx_count <= 6'h1F;
      tick(2);
      tx_count <= 6'h1D;
      tick(3);
      `CHK(irq, 1'b1)
      `CHK(transmit_ready_pin_n, 1'b1)
      wr(`UIC_ADDR_DATA, 8'h3C);
      tick(1);
      `CHK(tx_data, 8'h3C)
      `CHK(pushes, 1)
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      tx_count <= 6'h00;
      tick(3);
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      `CHK(transmit_ready_pin_n, 1'b0)
      rx_count <= 6'h08;
      tick(2);
      `CHK(receive_ready_pin_n, 1'b0)
      rd(`UIC_ADDR_ISTAT, 8'hC4);
      pulse(ev_ovr);
      rd(`UIC_ADDR_ISTAT, 8'hC6);
      rd(`UIC_ADDR_ISTAT, 8'hC6);
      rd(`UIC_ADDR_LSTAT, 8'h63);
      rd(`UIC_ADDR_ISTAT, 8'hC4);
      rx_head_err <= 3'h2;
      rx_any_err <= 1'b1;
      tick(2);
      rx_head_err <= 3'h0;
      rd(`UIC_ADDR_ISTAT, 8'hC6);
      rd(`UIC_ADDR_LSTAT, 8'hE9);
      rx_any_err <= 1'b0;
      rd(`UIC_ADDR_ISTAT, 8'hC4);
      rx_count <= 6'h07;
      tick(2);
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      modem_status <= 8'h01;
      tick(2);
      rd(`UIC_ADDR_ISTAT, 8'hC0);
      rd(`UIC_ADDR_MSTAT, 8'h01);
      modem_status <= 8'h00;
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      wr(`UIC_ADDR_IEN, 8'h00);
      rx_count <= 6'h08;
      tick(2);
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      `CHK(irq, 1'b0)
      rx_count <= 6'h00;
      $display("test priority done");
   endtask
   task automatic t_enh;
      enhanced_en <= 1'b1;
      auto_cts_en <= 1'b1;
      wr(`UIC_ADDR_IEN, 8'hB0);
      `CHK(sleep_en, 1'b1)
      pulse(ev_xoff);
      rd(`UIC_ADDR_ISTAT, 8'hD0);
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      pulse(ev_xoff);
      pulse(ev_xon);
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      pulse(ev_spec);
      `CHK(irq, 1'b1)
      pulse(ev_load);
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      pulse(ev_cts);
      rd(`UIC_ADDR_ISTAT, 8'hE0);
      rd(`UIC_ADDR_MSTAT, 8'h00);
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      `CHK(ms_rds, 2)
      enhanced_en <= 1'b0;
      pulse(ev_xoff);
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      `CHK(sleep_en, 1'b0)
      $display("test enhanced done");
   endtask
   task automatic t_tmo;
      wr(`UIC_ADDR_IEN, 8'h01);
      wr(`UIC_ADDR_ISTAT, 8'h09);
      rx_count <= 6'h01;
      tx_count <= 6'h05;
      pulse(ev_load);
      `CHK(receive_ready_pin_n, 1'b1)
      `CHK(transmit_ready_pin_n, 1'b0)
      tick(76);
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      tick(40);
      rd(`UIC_ADDR_ISTAT, 8'hCC);
      `CHK(receive_ready_pin_n, 1'b0)
      rd(`UIC_ADDR_DATA, 8'h5A);
      tick(2);
      `CHK(pops, 1)
      rd(`UIC_ADDR_ISTAT, 8'hC1);
      $display("test time-out done");
   endtask
   task automatic t_rst2;
      nrst <= 1'b0;
      tick(2);
      nrst <= 1'b1;
      rd(`UIC_ADDR_IEN, 8'h00);
      rd(`UIC_ADDR_ISTAT, 8'h01);
      `CHK(dma_mode, 1'b0)
      `CHK(rx_trig_level, 6'h08)
      `CHK(tx_trig_level, 6'h10)
      `CHK(irq, 1'b0)
      $display("test second reset done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      tick(20);
      nrst <= 1'b1;
      t_reset;
      t_fifo;
      t_prio;
      t_enh;
      t_tmo;
      t_rst2;
      report_and_stop;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      tick(5000);
      miscompares++;
      report_and_stop;
   end
endmodule
